// file: bench/pressure_signal_chain_selftest_bench.sv
`timescale 1ns/1ps
module pressure_signal_chain_selftest_bench;
  import pssc_pkg::*;
  localparam int ST = 200;
  localparam int OSR = 96 * 40;
  logic          mclk = 1'b0;
  logic          arst_n = 1'b0;
  pssc_apb_req_t req = '0;
  pssc_apb_rsp_t rsp;
  logic          irq, sdmStrobe, sdmBit, err;
  logic [15:0]   cmMeasure;
  logic [15:0]   cmLevel = 16'h0000;
  logic [7:0]    tempCode = 8'h00;
  logic [7:0]    density = 8'h80;
  logic [2:0]    supplyLow = 3'h0;
  logic [31:0]   rd;
  int            bad_count = 0;
  int            checked = 0;
  logic [15:0]   dig [4] = '{16'h8171, 16'h6C95, 16'h807A, 16'h78AC};
  logic [7:0]    ra [6] = '{A_CFG, A_STAT, A_RES, A_TRIM0, A_TRIM1, A_IMSK};
  logic [31:0]   rv [6] = '{32'h0, 32'h0, 32'h0, 32'h4000, 32'h0, 32'h0};

  pssc_core #(.ST_CYC(ST)) dut (.mclk(mclk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp), .irq(irq),
    .sdmStrobe(sdmStrobe), .sdmBit(sdmBit), .cmMeasure(cmMeasure), .tempCode(tempCode), .supplyLow(supplyLow));
  pssc_afe_model afe (.mclk(mclk), .arst_n(arst_n), .density(density), .cmLevel(cmLevel),
    .sdmStrobe(sdmStrobe), .sdmBit(sdmBit), .cmMeasure(cmMeasure));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [15:0] patExp(input logic [1:0] c);
    return {8{c[0], c[1]}};
  endfunction

  // Fixed-point rounding leaves a few LSB of slack
  function automatic logic near(input logic [15:0] g, input logic [15:0] e);
    logic signed [17:0] d;
    d = $signed({2'b0, g}) - $signed({2'b0, e});
    return (d <= 18'sd4) && (d >= -18'sd4);
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge mclk);
    bad_count++;
    close_out;
  end

  initial begin
    logic [31:0] t;
    logic [3:0]  c;
    logic [1:0]  k;
    logic        f;
    int          n;
    void'($urandom(34054));
    tempCode <= 8'($urandom);
    density <= 8'($urandom_range(200, 40));
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    t = $urandom;
    apb(1'b1, A_TRIM1, t);
    supplyLow <= 3'($urandom_range(7, 1));
    apb(1'b1, A_TRIM1, ~t);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, A_TRIM1, 32'h0);
    chk({30'h0, err, rd[0]}, 32'h2);
    supplyLow <= 3'h0;
    apb(1'b0, A_TRIM1, 32'h0);
    chk(rd, t);
    apb(1'b1, A_TRIM1, 32'h0);
    k = 2'($urandom);
    for (int i = 0; i < 8; i++) begin
      c = {i[2], 1'b1, k + 2'(i)};
      apb(1'b1, A_CFG, {28'h0, c});
      apb(1'b0, A_CFG, 32'h0);
      chk(rd & 32'hF, {28'h0, c});
      apb(1'b0, A_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b0, A_RES, 32'h0);
      if (!c[3]) chk(rd, {16'h0, patExp(c[1:0])});
    end
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    repeat (ST + 10) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    cmLevel <= 16'h8001 + 16'($urandom_range(1000));
    repeat (ST + 10) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    cmLevel <= 16'h8000;
    apb(1'b1, A_CFG, 32'h0);
    repeat (ST + 10) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h2);
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    repeat (ST + 10) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_IMSK, 32'h0);
    apb(1'b0, A_IST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_IMSK, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < OSR + 100) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, A_IST, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b0, A_IST, 32'h0);
    chk(rd & 32'h1, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    // Trim is bypassed in digital self-test, so any trim must still land
    f = 1'($urandom);
    apb(1'b1, A_TRIM0, $urandom);
    apb(1'b1, A_CFG, {27'h0, f, 2'b11, k});
    n = 0;
    do begin
      repeat (OSR) @(posedge mclk);
      apb(1'b0, A_RES, 32'h0);
      n++;
    end while (!near(rd[15:0], dig[k]) && n < 8);
    chk({31'h0, near(rd[15:0], dig[k])}, 32'h1);
    apb(1'b1, A_CFG, 32'h105);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h100);
    apb(1'b1, A_CFG, 32'h00C);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h9, 32'h8);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_CFG, 32'h6);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h6);
    close_out;
  end
endmodule

// file: bench/pssc_afe_model.sv
`timescale 1ns/1ps
module pssc_afe_model (
  input  wire logic        mclk,      // Clock
  input  wire logic        arst_n,    // Reset, active low
  input  wire logic [7:0]  density,   // Ones density of stream
  input  wire logic [15:0] cmLevel,   // Common-mode level
  output logic             sdmStrobe, // One pulse per sample
  output logic             sdmBit,    // Modulator bit
  output logic [15:0]      cmMeasure  // Common-mode measurement
);
  logic [5:0] divCnt_r;
  logic [8:0] acc_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r  <= 6'h00;
      sdmStrobe <= 1'b0;
      acc_r     <= 9'h000;
      sdmBit    <= 1'b0;
    end else begin
      divCnt_r  <= (divCnt_r == 6'd39) ? 6'h00 : divCnt_r + 6'h01;
      sdmStrobe <= (divCnt_r == 6'd39);
      // Bit is valid only with its strobe; it toggles in between
      if (divCnt_r == 6'd39) begin
        acc_r  <= {1'b0, acc_r[7:0]} + {1'b0, density};
        sdmBit <= acc_r[8];
      end else begin
        sdmBit <= ~sdmBit;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cmMeasure <= 16'h0000;
    else cmMeasure <= cmLevel;
  end
endmodule

// file: core/pssc_core.sv
`timescale 1ns/1ps
module pssc_sinc3 #(
  parameter int W = 16,
  parameter int R = 24
) (
  input  wire logic         mclk,   // Clock
  input  wire logic         arst_n, // Async reset, active low
  input  wire logic         inV,    // Input sample strobe
  input  wire logic [W-1:0] inD,    // Input sample
  output logic              outV,   // Decimated sample strobe
  output logic      [W-1:0] outD    // Decimated sample, gain R**3
);
  localparam int CW = $clog2(R);
  logic [W-1:0]  i1R, i2R, i3R, c1R, c2R, c3R, d1, d2;
  logic [CW-1:0] cntR;
  logic          decR;

  // Modular arithmetic: wrap in the integrators cancels in the combs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      i1R  <= '0;
      i2R  <= '0;
      i3R  <= '0;
      cntR <= '0;
      decR <= 1'b0;
    end else begin
      decR <= inV && cntR == CW'(R - 1);
      if (inV) begin
        i1R  <= i1R + inD;
        i2R  <= i2R + i1R;
        i3R  <= i3R + i2R;
        cntR <= (cntR == CW'(R - 1)) ? '0 : cntR + 1'b1;
      end
    end
  end

  assign d1 = i3R - c1R;
  assign d2 = d1 - c2R;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c1R  <= '0;
      c2R  <= '0;
      c3R  <= '0;
      outD <= '0;
      outV <= 1'b0;
    end else begin
      outV <= decR;
      if (decR) begin
        c1R  <= i3R;
        c2R  <= d1;
        c3R  <= d2;
        outD <= d2 - c3R;
      end
    end
  end

  property p_dec;
    @(posedge mclk) disable iff (!arst_n) inV && cntR == CW'(R - 1) |-> ##2 outV;
  endproperty
  a_dec: assert property (p_dec) else $error("decimated sample missing");
endmodule

module pssc_core import pssc_pkg::*; #(
  parameter int ST_CYC = ST_PERIOD_CYC // Self-test period in clocks
) (
  input  wire logic          mclk,      // 40 MHz clock
  input  wire logic          arst_n,    // Async reset, active low
  input  wire pssc_apb_req_t apbReq,    // APB request
  output pssc_apb_rsp_t      apbRsp,    // APB response, registered
  output logic               irq,       // Level interrupt, registered
  input  wire logic          sdmStrobe, // 1 MHz modulator sample strobe
  input  wire logic          sdmBit,    // Modulator bitstream
  input  wire logic [15:0]   cmMeasure, // Common-mode measurement
  input  wire logic [7:0]    tempCode,  // Die temperature, signed
  input  wire logic [2:0]    supplyLow  // Low flags: VCC, core, analog
);
  logic [3:0]  selR;
  logic        filtR, lockR, failR, uvPrevR, failPrevR, iirV;
  logic [15:0] gainR, offR, nlR, tcoR, resultR;
  logic [2:0]  istR, imskR, ev, clrMask;
  pssc_cm_t    cmR;
  logic [$clog2(ST_CYC)-1:0] cntR;
  logic        uv, cmSel, digSel, patSel, running, setup, done, wrOk, wrCfg, hit, endP, over;
  logic [31:0] rdMux;

  assign uv      = |supplyLow;
  assign cmSel   = selR == SEL_CM;
  assign digSel  = selR[3:2] == 2'b11;
  assign patSel  = selR[3:2] == 2'b01;
  assign running = cmR != CM_IDLE || digSel || patSel;
  assign setup   = apbReq.psel && !apbReq.penable;
  assign done    = apbReq.psel && apbReq.penable && apbRsp.pready;
  assign wrOk    = done && apbReq.pwrite && !apbRsp.pslverr;
  assign wrCfg   = wrOk && apbReq.paddr == A_CFG;

  always_comb begin
    hit   = 1'b1;
    rdMux = '0;
    unique case (apbReq.paddr)
      A_CFG:   rdMux = {23'h0, lockR, 3'h0, filtR, selR};
      A_STAT:  rdMux = {28'h0, lockR, uv, failR, running};
      A_RES:   rdMux = {16'h0, resultR};
      A_TRIM0: rdMux = {offR, gainR};
      A_TRIM1: rdMux = {tcoR, nlR};
      A_IST:   rdMux = {29'h0, istR};
      A_IMSK:  rdMux = {29'h0, imskR};
      default: hit = 1'b0;
    endcase
  end

  // One wait-free access phase: answer is prepared during setup
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= setup;
      apbRsp.pslverr <= setup && (uv || !hit);
      apbRsp.prdata  <= (setup && !uv && !apbReq.pwrite) ? rdMux : '0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      selR  <= SEL_RST;
      lockR <= 1'b0;
      filtR <= 1'b0;
    end else begin
      if (wrCfg && apbReq.pwdata[CFG_LOCK]) lockR <= 1'b1;
      if (wrCfg) filtR <= apbReq.pwdata[CFG_FILT];
      if (lockR || (wrCfg && apbReq.pwdata[CFG_LOCK])) begin
        selR <= SEL_RST;
      end else if (wrCfg) begin
        selR <= apbReq.pwdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gainR <= GAIN_RST;
      offR  <= ZERO16;
      nlR   <= ZERO16;
      tcoR  <= ZERO16;
      imskR <= MASK_RST;
    end else if (wrOk) begin
      if (apbReq.paddr == A_TRIM0) {offR, gainR} <= apbReq.pwdata;
      if (apbReq.paddr == A_TRIM1) {tcoR, nlR} <= apbReq.pwdata;
      if (apbReq.paddr == A_IMSK) imskR <= apbReq.pwdata[2:0];
    end
  end

  // Common-mode self-test sequencer
  assign endP = cntR == ($bits(cntR))'(ST_CYC - 1);
  assign over = cmMeasure > CM_LIMIT;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmR   <= CM_IDLE;
      cntR  <= '0;
      failR <= 1'b0;
    end else begin
      cntR <= endP ? '0 : cntR + 1'b1;
      unique case (cmR)
        CM_IDLE: begin
          if (cmSel) begin
            cmR   <= CM_RUN;
            failR <= 1'b0;
            cntR  <= '0;
          end
        end
        CM_RUN: begin
          if (endP) failR <= failR | over;
          if (!cmSel) cmR <= endP ? CM_IDLE : CM_FINAL;
        end
        CM_FINAL: begin
          if (endP) begin
            failR <= failR | over;
            cmR   <= CM_IDLE;
          end
        end
        default: cmR <= CM_IDLE;
      endcase
    end
  end

  // Decimation chain
  logic        s1V, s2V;
  logic [15:0] s1Raw, s1N, s2N, sincOut;
  logic [23:0] s2Raw;
  logic [31:0] p1;

  pssc_sinc3 #(.W(16), .R(DEC1)) u_sinc1 (
    .mclk   (mclk),
    .arst_n (arst_n),
    .inV    (sdmStrobe),
    .inD    ({15'h0, sdmBit}),
    .outV   (s1V),
    .outD   (s1Raw)
  );

  assign p1  = 32'(s1Raw) * 32'(NORM1);
  assign s1N = p1[NORM_SH +: 16];

  pssc_sinc3 #(.W(24), .R(DEC2)) u_sinc2 (
    .mclk   (mclk),
    .arst_n (arst_n),
    .inV    (s1V),
    .inD    ({8'h0, s1N}),
    .outV   (s2V),
    .outD   (s2Raw)
  );

  assign s2N     = s2Raw[NORM2_SH +: 16];
  assign sincOut = digSel ? INJ[filtR][selR[1:0]] : s2N;

  // Trim; bypassed under digital self-test so the constants stay exact
  logic signed [63:0] xs, g, sq, nlv, tcv;
  logic signed [39:0] tr;

  always_comb begin
    xs  = 64'(sincOut);
    g   = (xs * $signed(gainR)) >>> 14;
    sq  = (xs * xs) >>> 16;
    nlv = (sq * $signed(nlR)) >>> 14;
    tcv = $signed(tempCode) * $signed(tcoR);
    tr  = digSel ? 40'(xs) : 40'(g + nlv + tcv + $signed(offR));
  end

  // Direct form I, sections share the middle delay line
  function automatic logic signed [39:0] bq(input logic signed [39:0] a, b, c, d, e, input logic f, input int k);
    logic signed [79:0] s;
    s = a * CQ[f][k] + b * CQ[f][k+1] + c * CQ[f][k+2] - d * CQ[f][k+3] - e * CQ[f][k+4];
    return s[QF+39:QF];
  endfunction

  function automatic logic [15:0] sat16(input logic signed [79:0] v);
    if (v < 0) return 16'h0000;
    if (v > 80'sd65535) return 16'hFFFF;
    return v[15:0];
  endfunction

  logic signed [39:0] x0, y0, v0, x1R, x2R, y1R, y2R, v1R, v2R;
  logic signed [79:0] o, oR;
  logic               iirStep;

  // Digital self-test steps the filter every clock: input is constant, so it settles in microseconds.
  // Limitation: the new-sample status bit then sets on every clock.
  assign iirStep = s2V || digSel;

  assign x0 = tr <<< DF;
  assign y0 = bq(x0, x1R, x2R, y1R, y2R, filtR, 1);
  assign v0 = bq(y0, y1R, y2R, v1R, v2R, filtR, 6);
  assign o  = (v0 * CQ[filtR][0]) >>> (QF + DF);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {x1R, x2R, y1R, y2R, v1R, v2R} <= '0;
      oR   <= '0;
      iirV <= 1'b0;
    end else begin
      iirV <= iirStep;
      if (iirStep) begin
        x1R <= x0;
        x2R <= x1R;
        y1R <= y0;
        y2R <= y1R;
        v1R <= v0;
        v2R <= v1R;
        oR  <= o;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resultR <= ZERO16;
    end else if (patSel) begin
      resultR <= PAT[selR[1:0]];
    end else if (iirV) begin
      resultR <= sat16(oR);
    end
  end

  // Status events; a read of the status clears only the bits it returned
  assign ev      = {uv && !uvPrevR, failR && !failPrevR, iirV};
  assign clrMask = (done && !apbReq.pwrite && !apbRsp.pslverr && apbReq.paddr == A_IST) ? apbRsp.prdata[2:0] : 3'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      istR      <= 3'h0;
      uvPrevR   <= 1'b0;
      failPrevR <= 1'b0;
      irq       <= 1'b0;
    end else begin
      uvPrevR   <= uv;
      failPrevR <= failR;
      istR      <= (istR & ~clrMask) | ev;
      irq       <= |(istR & imskR);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_cmStart;
    cmR == CM_IDLE && cmSel;
  endsequence
  sequence s_cmLeave;
    cmR == CM_RUN && !cmSel && endP;
  endsequence

  property p_uvAbort;
    setup && uv |=> apbRsp.pready && apbRsp.pslverr && apbRsp.prdata == 32'h0;
  endproperty
  a_uvAbort: assert property (p_uvAbort) else $error("access not aborted in undervoltage");

  property p_selWr;
    wrCfg && !lockR && !apbReq.pwdata[CFG_LOCK] |=> selR == $past(apbReq.pwdata[3:0]);
  endproperty
  a_selWr: assert property (p_selWr) else $error("select write lost");

  property p_lock;
    lockR |-> selR == SEL_RST && lockR throughout ##1 selR == SEL_RST;
  endproperty
  a_lock: assert property (p_lock) else $error("select not held at zero");

  property p_cmStart;
    s_cmStart |=> running && !failR && cmR == CM_RUN;
  endproperty
  a_cmStart: assert property (p_cmStart) else $error("common-mode start wrong");

  property p_final;
    s_cmLeave |=> cmR == CM_IDLE && failR == $past(failR | over);
  endproperty
  a_final: assert property (p_final) else $error("final result not posted");

  property p_hold;
    cmR == CM_FINAL |-> running;
  endproperty
  a_hold: assert property (p_hold) else $error("running dropped early");

  property p_pat;
    patSel ##1 $stable(selR) |-> resultR == PAT[selR[1:0]];
  endproperty
  a_pat: assert property (p_pat) else $error("pattern not forced");

  property p_run;
    setup && !apbReq.pwrite && apbReq.paddr == A_STAT && !uv && (digSel || patSel) |=> apbRsp.prdata[STAT_RUN];
  endproperty
  a_run: assert property (p_run) else $error("running flag not shown");

  property p_irq;
    |(istR & imskR) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// file: shared/pssc_pkg.sv
package pssc_pkg;
  // Timing
  localparam int CLK_MHZ       = 40;
  localparam int ST_PERIOD_US  = 1000;
  localparam int ST_PERIOD_CYC = ST_PERIOD_US * CLK_MHZ;

  // Decimation
  localparam int DEC1     = 24;
  localparam int DEC2     = 4;
  localparam int NORM_SH  = 8;
  localparam int NORM1    = (1 << (16 + NORM_SH)) / (DEC1 ** 3);
  localparam int NORM2_SH = $clog2(DEC2 ** 3);
  localparam int QF       = 28;
  localparam int DF       = 12;

  // Register byte addresses
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_RES   = 8'h08;
  localparam logic [7:0] A_TRIM0 = 8'h0C;
  localparam logic [7:0] A_TRIM1 = 8'h10;
  localparam logic [7:0] A_IST   = 8'h14;
  localparam logic [7:0] A_IMSK  = 8'h18;

  // Field positions
  localparam int CFG_FILT  = 4;
  localparam int CFG_LOCK  = 8;
  localparam int STAT_RUN  = 0;
  localparam int STAT_FAIL = 1;
  localparam int STAT_UV   = 2;
  localparam int STAT_LOCK = 3;
  localparam int IRQ_SMP   = 0;
  localparam int IRQ_FAIL  = 1;
  localparam int IRQ_UV    = 2;

  // Reset values
  localparam logic [3:0]  SEL_RST  = 4'h0;
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic [15:0] ZERO16   = 16'h0000;
  localparam logic [2:0]  MASK_RST = 3'h0;

  // Self-test codes and values
  localparam logic [3:0]  SEL_CM   = 4'h1;
  localparam logic [15:0] CM_LIMIT = 16'h8000;
  localparam logic [15:0] PAT [4]  = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};
  localparam real         DIG [4]  = '{real'(16'h8171), real'(16'h6C95), real'(16'h807A), real'(16'h78AC)};

  function automatic logic signed [31:0] q(input real r);
    return 32'($rtoi(r * (2.0 ** QF)));
  endfunction

  // Order: a0, n11 n12 n13 d12 d13, n21 n22 n23 d22 d23
  localparam logic signed [31:0] CQ [2][11] = '{
    '{q(0.088642612609670), q(0.029638050039039), q(0.087543281056143), q(0.029695285913601),
      q(-1.422792640957290), q(0.511435253566960), q(0.250241278804809), q(0.499999767379068),
      q(0.249758953816089), q(-1.503329908017845), q(0.621996524706640)},
    '{q(0.129604264748411), q(0.043719804402508), q(0.087543281056143), q(0.043823599710731),
      q(-1.300502656562698), q(0.430106921311110), q(0.250296586927511), q(0.499999648540934),
      q(0.249703764531484), q(-1.379959571988366), q(0.555046257157745)}};

  function automatic real dcg(input int f);
    real c [11];
    for (int k = 0; k < 11; k++) c[k] = real'(CQ[f][k]) / (2.0 ** QF);
    return c[0] * (c[1] + c[2] + c[3]) / (1.0 + c[4] + c[5]) * (c[6] + c[7] + c[8]) / (1.0 + c[9] + c[10]);
  endfunction

  // Sinc-output constants chosen so the filtered result settles on the targets
  localparam logic [15:0] INJ [2][4] = '{
    '{16'($rtoi(DIG[0] / dcg(0) + 0.5)), 16'($rtoi(DIG[1] / dcg(0) + 0.5)),
      16'($rtoi(DIG[2] / dcg(0) + 0.5)), 16'($rtoi(DIG[3] / dcg(0) + 0.5))},
    '{16'($rtoi(DIG[0] / dcg(1) + 0.5)), 16'($rtoi(DIG[1] / dcg(1) + 0.5)),
      16'($rtoi(DIG[2] / dcg(1) + 0.5)), 16'($rtoi(DIG[3] / dcg(1) + 0.5))}};

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pssc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pssc_apb_rsp_t;

  typedef enum logic [2:0] {
    CM_IDLE  = 3'b001,
    CM_RUN   = 3'b010,
    CM_FINAL = 3'b100
  } pssc_cm_t;
endpackage
